// File: hw/adc_flow_pkg.sv
package adc_flow_pkg;

	// Bit positions in the conversion_flow_control register.
	localparam int ABORT_BIT = 7;
	localparam int KICKOFF_BIT = 6;
	localparam int RESTART_BIT = 5;
	localparam int REG_WIDTH = 8;

	// Bits of access_source_select.
	localparam int ACC_BUS_BIT = 0;
	localparam int ACC_INT_BIT = 1;

	// Bus clock cycles after enable before the flow bits may change.
	localparam int ENABLE_LATENCY = 3;

	localparam logic [REG_WIDTH-1:0] FLOW_RESET = 8'h00;

	// Converter state reported by the sequencer core.
	typedef struct packed {
		logic boundary;
		logic idle;
		logic busy;
		logic sampleStart;
		logic endOfList;
		logic cmdLoaded;
	} convStatus_t;

	// Requests raised on the internal interface lines.
	typedef struct packed {
		logic abortReq;
		logic kickoffReq;
		logic restartReq;
	} intReq_t;

	// Commands to the sequencer core.
	typedef struct packed {
		logic abortSequence;
		logic startSequence;
		logic loadTopCommand;
	} seqCmd_t;

endpackage

// File: hw/adc_sequence_flow_control.sv
// Function
// [R1] Abort bit 7, kickoff bit 6, one pending.
// [R2] Pending abort stops sequence at next boundary.
// [R3] Abort clears itself once aborted and idle.
// [R4] Requests set only when enabled; else zero.
// [R5] Writing zero to request bits does nothing.
// [R6] Bus abort write while set flags overrun.
// [R7] Internal abort request while set flags overrun.
// [R8] Access field picks bus or internal sources.
// [R9] Restart sets abort unless aborted or list end.
// [R10] Automatic abort sets unexpected restart error.
// [R11] Kickoff starts sequence only when nothing busy.
// [R12] Kickoff clears when first sample begins.
// [R13] Bus kickoff write while set flags overrun.
// [R14] Internal kickoff while set flags overrun.
// [R15] Bits writable three cycles after enabling.
// [R16] Disable or soft reset clears all bits.
// [R17] Restart loads top command, clears when loaded.
// [R18] Trigger mode restart also sets kickoff; code does so only at list end or with an abort pending or done.
module adc_sequence_flow_control (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic converterEnable,
	input wire logic softReset,
	input wire logic triggerMode,
	input wire logic [1:0] accessSourceSelect,
	input wire logic regWrite,
	input wire logic [adc_flow_pkg::REG_WIDTH-1:0] regWriteData,
	output logic [adc_flow_pkg::REG_WIDTH-1:0] regReadData,
	input wire adc_flow_pkg::intReq_t intReq,
	input wire adc_flow_pkg::convStatus_t convStatus,
	input wire logic errorClear,
	output adc_flow_pkg::seqCmd_t seqCmd,
	output logic abortOverrun,
	output logic restartOverrun,
	output logic unexpectedRestartError,
	output logic kickoffOverrunError
);
	import adc_flow_pkg::*;

	logic flowReady;
	logic busSel;
	logic intSel;
	logic clearAll;
	logic abortReqIn;
	logic kickReqIn;
	logic restartReqIn;
	logic restartNew;
	logic autoAbort;
	logic autoKick;
	logic abortDone;

	logic abort_r;
	logic abort_nxt;
	logic kick_r;
	logic kick_nxt;
	logic restart_r;
	logic restart_nxt;
	logic aborted_r;
	logic aborted_nxt;
	logic abortOvr_r;
	logic abortOvr_nxt;
	logic restartOvr_r;
	logic restartOvr_nxt;
	logic rstErr_r;
	logic rstErr_nxt;
	logic kickErr_r;
	logic kickErr_nxt;

	enable_latency #(
		.LATENCY(ENABLE_LATENCY)
	) u_latency (
		.clk_sys(clk_sys),
		.reset(reset),
		.enable(converterEnable && !softReset),
		.ready(flowReady)
	);

	// Source selection; only ones written by the bus, or internal lines raised while selected, count as requests.
	assign busSel = accessSourceSelect[ACC_BUS_BIT]; // R8
	assign intSel = accessSourceSelect[ACC_INT_BIT]; // R8
	assign abortReqIn = flowReady && ((busSel && regWrite && regWriteData[ABORT_BIT])
		|| (intSel && intReq.abortReq)); // R4 R5 R15
	assign kickReqIn = flowReady && ((busSel && regWrite && regWriteData[KICKOFF_BIT])
		|| (intSel && intReq.kickoffReq)); // R4 R5 R15
	assign restartReqIn = flowReady && ((busSel && regWrite && regWriteData[RESTART_BIT])
		|| (intSel && intReq.restartReq)); // R15
	assign clearAll = !converterEnable || softReset; // R16

	assign restartNew = restartReqIn && !restart_r;
	assign autoAbort = restartNew && !abort_r && !aborted_r && !convStatus.endOfList; // R9
	assign autoKick = triggerMode && restartNew
		&& (convStatus.endOfList || aborted_r || abort_r); // R18
	assign abortDone = abort_r && convStatus.idle && !convStatus.busy; // R3

	always_comb begin
		abort_nxt = abort_r;
		kick_nxt = kick_r;
		restart_nxt = restart_r;
		aborted_nxt = aborted_r;
		abortOvr_nxt = 1'b0;
		restartOvr_nxt = 1'b0;
		rstErr_nxt = rstErr_r;
		kickErr_nxt = kickErr_r;
		if (clearAll) begin
			abort_nxt = 1'b0; // R4
			kick_nxt = 1'b0; // R4
			restart_nxt = 1'b0;
			aborted_nxt = 1'b0;
			rstErr_nxt = 1'b0; // R16
			kickErr_nxt = 1'b0; // R16
		end else begin
			if (abortDone) begin
				abort_nxt = 1'b0; // R3
				aborted_nxt = 1'b1;
			end
			if (abortReqIn || autoAbort) begin
				abort_nxt = 1'b1; // R9
			end
			if (seqCmd.startSequence) begin
				aborted_nxt = 1'b0;
			end
			if (kick_r && convStatus.sampleStart) begin
				kick_nxt = 1'b0; // R12
			end
			if (kickReqIn || autoKick) begin
				kick_nxt = 1'b1; // R18
			end
			if (restart_r && convStatus.cmdLoaded) begin
				restart_nxt = 1'b0; // R17
			end
			if (restartReqIn) begin
				restart_nxt = 1'b1;
			end
			abortOvr_nxt = abortReqIn && abort_r; // R6 R7
			restartOvr_nxt = restartReqIn && restart_r;
			if (errorClear) begin
				rstErr_nxt = 1'b0;
				kickErr_nxt = 1'b0;
			end
			if (autoAbort) begin
				rstErr_nxt = 1'b1; // R10
			end
			if (kickReqIn && kick_r) begin
				kickErr_nxt = 1'b1; // R13 R14
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			abort_r <= 1'b0;
			kick_r <= 1'b0;
			restart_r <= 1'b0;
			aborted_r <= 1'b0;
			abortOvr_r <= 1'b0;
			restartOvr_r <= 1'b0;
			rstErr_r <= 1'b0;
			kickErr_r <= 1'b0;
		end else begin
			abort_r <= abort_nxt;
			kick_r <= kick_nxt;
			restart_r <= restart_nxt;
			aborted_r <= aborted_nxt;
			abortOvr_r <= abortOvr_nxt;
			restartOvr_r <= restartOvr_nxt;
			rstErr_r <= rstErr_nxt;
			kickErr_r <= kickErr_nxt;
		end
	end

	always_comb begin
		regReadData = FLOW_RESET;
		regReadData[ABORT_BIT] = abort_r; // R1
		regReadData[KICKOFF_BIT] = kick_r; // R1
		regReadData[RESTART_BIT] = restart_r;
	end

	assign seqCmd.abortSequence = abort_r && convStatus.boundary; // R2
	assign seqCmd.startSequence = kick_r && !abort_r && !restart_r
		&& !convStatus.busy; // R11
	assign seqCmd.loadTopCommand = restart_r && !abort_r && !convStatus.busy; // R17
	assign abortOverrun = abortOvr_r;
	assign restartOverrun = restartOvr_r;
	assign unexpectedRestartError = rstErr_r;
	assign kickoffOverrunError = kickErr_r;

	bit_one_a: assert property (@(posedge clk_sys) disable iff (reset)
		regReadData[ABORT_BIT] == abort_r && regReadData[KICKOFF_BIT] == kick_r)
		else $error("flow bits misplaced in read data"); // R1
	abort_boundary_a: assert property (@(posedge clk_sys) disable iff (reset)
		(abort_r && convStatus.boundary) |-> seqCmd.abortSequence)
		else $error("abort not issued at boundary"); // R2
	abort_autoclear_a: assert property (@(posedge clk_sys) disable iff (reset)
		(abortDone && !abortReqIn && !autoAbort) |=> !abort_r)
		else $error("abort did not clear when idle"); // R3
	disable_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
		clearAll |=> !abort_r && !kick_r && !restart_r && !kickErr_r)
		else $error("flow bits not cleared on disable"); // R4
	zero_write_a: assert property (@(posedge clk_sys) disable iff (reset)
		(abort_r && !clearAll && !abortDone) |=> abort_r)
		else $error("abort dropped without completion"); // R5
	abort_overrun_a: assert property (@(posedge clk_sys) disable iff (reset)
		(abortReqIn && abort_r && !clearAll) |=> abortOverrun && abort_r)
		else $error("abort overrun missed"); // R6
	latency_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(converterEnable) |-> !flowReady ##1 !flowReady ##1 !flowReady)
		else $error("flow bits writable too early"); // R15
	auto_abort_a: assert property (@(posedge clk_sys) disable iff (reset)
		(autoAbort && !clearAll) |=> abort_r && unexpectedRestartError)
		else $error("restart did not raise abort and error"); // R10
	start_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
		seqCmd.startSequence |-> !convStatus.busy && kick_r)
		else $error("sequence started while busy"); // R11
	kick_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
		(kick_r && convStatus.sampleStart && !kickReqIn && !autoKick) |=> !kick_r)
		else $error("kickoff not cleared on sampling"); // R12
	kick_overrun_a: assert property (@(posedge clk_sys) disable iff (reset)
		(kickReqIn && kick_r && !clearAll) |=> kickoffOverrunError && kick_r)
		else $error("kickoff overrun missed"); // R13

endmodule // adc_sequence_flow_control

// File: hw/enable_latency.sv
module enable_latency #(
	parameter int LATENCY = adc_flow_pkg::ENABLE_LATENCY
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic enable,
	output logic ready
);
	import adc_flow_pkg::*;

	localparam int CW = $clog2(LATENCY + 1);
	localparam logic [CW-1:0] LAT = CW'(LATENCY);

	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;

	always_comb begin
		count_nxt = count_r;
		if (!enable) begin
			count_nxt = '0;
		end else if (count_r != LAT) begin
			count_nxt = count_r + CW'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign ready = enable && (count_r == LAT);

endmodule // enable_latency

// File: tb/adc_sequence_flow_control_tb.sv
module adc_sequence_flow_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import adc_flow_pkg::*;
	logic clk_sys, reset, converterEnable, softReset, triggerMode, regWrite, errorClear, eol;
	logic [1:0] accessSourceSelect;
	logic [7:0] regWriteData, regReadData;
	intReq_t intReq;
	convStatus_t convStatus;
	seqCmd_t seqCmd;
	logic abortOverrun, restartOverrun, unexpectedRestartError, kickoffOverrunError;
	int failCount, samplesChecked;
	adc_sequence_flow_control i_dut (.clk_sys, .reset, .converterEnable, .softReset,
		.triggerMode, .accessSourceSelect, .regWrite, .regWriteData, .regReadData, .intReq,
		.convStatus, .errorClear, .seqCmd, .abortOverrun, .restartOverrun,
		.unexpectedRestartError, .kickoffOverrunError);
	seq_core_model i_core (.clk_sys, .reset, .seqCmd, .endOfList(eol), .convStatus);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic stopTest();
		$display("Checks %0d, mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			failCount++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regWriteData <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		#1;
	endtask
	task automatic ip(input intReq_t r);
		@(posedge clk_sys);
		intReq <= r;
		@(posedge clk_sys);
		intReq <= '0;
		#1;
	endtask
	task automatic waitQuiet();
		for (int i = 0; i < 60 && (convStatus.busy !== 1'b0 || regReadData !== 8'h00); i++)
			@(posedge clk_sys);
		#1;
	endtask
	task automatic latencyTest();
		@(posedge clk_sys);
		converterEnable <= 1'b1;
		wr(8'hc0);
		chk(regReadData, 8'h00);
		repeat (3) @(posedge clk_sys);
		wr(8'h00);
		chk(regReadData, 8'h00);
	endtask
	task automatic kickTest();
		wr(8'h40);
		chk({regReadData[7:6], 5'h0, seqCmd.startSequence}, 8'h41);
		repeat (2) @(posedge clk_sys);
		#1;
		chk(regReadData, 8'h00);
		wr(8'h40);
		chk({regReadData[7:1], seqCmd.startSequence}, 8'h40);
		wr(8'h40);
		chk({regReadData[7:1], kickoffOverrunError}, 8'h41);
		@(posedge clk_sys);
		errorClear <= 1'b1;
		@(posedge clk_sys);
		errorClear <= 1'b0;
		waitQuiet();
		chk({regReadData[7:1], kickoffOverrunError}, 8'h00);
	endtask
	task automatic abortTest();
		wr(8'h40);
		wr(8'h80);
		wr(8'h80);
		chk({regReadData[7], 6'h0, abortOverrun}, 8'h81);
		repeat (6) @(posedge clk_sys);
		#1;
		chk({regReadData[7], 6'h0, convStatus.busy}, 8'h00);
	endtask
	task automatic intTest();
		accessSourceSelect <= 2'h2;
		wr(8'h40);
		chk(regReadData, 8'h00);
		ip(3'h2);
		@(posedge clk_sys);
		ip(3'h2);
		ip(3'h2);
		chk({regReadData[6], 6'h0, kickoffOverrunError}, 8'h81);
		ip(3'h4);
		ip(3'h4);
		chk({regReadData[7], 6'h0, abortOverrun}, 8'h81);
		waitQuiet();
	endtask
	task automatic restartTest();
		ip(3'h2);
		ip(3'h1);
		chk({regReadData[7:5], 4'h0, unexpectedRestartError}, 8'ha1);
		waitQuiet();
		chk(regReadData, 8'h00);
		triggerMode <= 1'b1;
		ip(3'h1);
		chk(regReadData, 8'h60);
		ip(3'h1);
		chk({regReadData[7:1], restartOverrun}, 8'h61);
		waitQuiet();
		eol <= 1'b1;
		ip(3'h1);
		chk(regReadData, 8'h60);
		waitQuiet();
		eol <= 1'b0;
		@(posedge clk_sys);
		accessSourceSelect <= 2'h1;
		converterEnable <= 1'b0;
		wr(8'hc0);
		chk({regReadData[7:2], unexpectedRestartError, kickoffOverrunError}, 8'h00);
	endtask
	task automatic softResetTest();
		@(posedge clk_sys);
		converterEnable <= 1'b1;
		repeat (4) @(posedge clk_sys);
		wr(8'h40);
		chk(regReadData, 8'h40);
		softReset <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk(regReadData, 8'h00);
		softReset <= 1'b0;
		wr(8'h40);
		chk(regReadData, 8'h00);
	endtask
	initial begin
		reset = 1'b1;
		converterEnable = 1'b0;
		softReset = 1'b0;
		triggerMode = 1'b0;
		regWrite = 1'b0;
		errorClear = 1'b0;
		eol = 1'b0;
		accessSourceSelect = 2'h1;
		regWriteData = 8'h00;
		intReq = '0;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		latencyTest();
		kickTest();
		abortTest();
		intTest();
		restartTest();
		softResetTest();
		stopTest();
	end
	initial begin
		#200000;
		failCount++;
		stopTest();
	end
endmodule // adc_sequence_flow_control_tb

// File: tb/seq_core_model.sv
module seq_core_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire adc_flow_pkg::seqCmd_t seqCmd,
	input wire logic endOfList,
	output adc_flow_pkg::convStatus_t convStatus
);
	timeunit 1ns;
	timeprecision 1ns;
	import adc_flow_pkg::*;
	logic [3:0] cnt_r;
	logic loaded_r;
	// A sequence lasts twelve cycles and stops early at a boundary on abort.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_r <= 4'h0;
			loaded_r <= 1'b0;
		end else begin
			loaded_r <= seqCmd.loadTopCommand && !loaded_r;
			if (seqCmd.abortSequence && convStatus.boundary) cnt_r <= 4'h0;
			else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
			else if (seqCmd.startSequence) cnt_r <= 4'hc;
		end
	end
	assign convStatus = '{boundary: cnt_r == 4'h6 || cnt_r == 4'h1, idle: cnt_r == 4'h0,
		busy: cnt_r != 4'h0, sampleStart: cnt_r == 4'hc, endOfList: endOfList,
		cmdLoaded: loaded_r};
endmodule // seq_core_model
